// File: logic/ddr2_pm_ctrl.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ddr2_pm_defs.svh"

// Behaviour
// - Refresh only with banks idle for tRP.
// - Wait tRFC after refresh before next.
// - At most eight refreshes postponed.
// - ODT off before self refresh entry.
// - Hold CKE low during self refresh.
// - Clock may stop; restart before exit.
// - Only NOP for tXSNR after exit.
// - CKE high throughout tXSRD, ODT off.
// - One refresh before self refresh re-entry.
// - No power-down during bursts or recovery.
// - Power-down without locked DLL needs reset.
// - Power-down shorter than nine refresh intervals.
// - CKE high with NOP, then exit latency.
// - CKE drop: wait, stop clock, reinitialise.
// - Frequency change only in precharge power-down.
// - Stable clock after change, DLL reset.
module ddr2_pm_ctrl #(
  parameter int unsigned REFI_CK = `PM_T_REFI_CK,
  parameter int unsigned XSRD_CK = `PM_T_XSRD_CK
) (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Memory pins
  output logic             ddr_ck_o,
  output logic             ddr_ck_n_o,
  output logic             ddr_cke_o,
  output logic             ddr_cs_n_o,
  output logic             ddr_ras_n_o,
  output logic             ddr_cas_n_o,
  output logic             ddr_we_n_o,
  output logic             ddr_odt_o
);

  localparam ddr2_pm_pkg::cnt_t RP    = 16'(`PM_T_RP_CK);
  localparam ddr2_pm_pkg::cnt_t RFC   = 16'(`PM_T_RFC_CK);
  localparam ddr2_pm_pkg::cnt_t XSNR  = 16'(`PM_T_XSNR_CK);
  localparam ddr2_pm_pkg::cnt_t XSRD  = 16'(XSRD_CK);
  localparam ddr2_pm_pkg::cnt_t XP    = 16'(`PM_T_XP_CK);
  localparam ddr2_pm_pkg::cnt_t XARD  = 16'(`PM_T_XARD_CK);
  localparam ddr2_pm_pkg::cnt_t XARDS = 16'(`PM_T_XARDS_CK);
  localparam ddr2_pm_pkg::cnt_t CKEM  = 16'(`PM_T_CKE_CK);
  localparam ddr2_pm_pkg::cnt_t DLY   = 16'(`PM_T_DELAY_CK);
  localparam ddr2_pm_pkg::cnt_t STAB  = 16'(`PM_STABLE_CK);
  localparam ddr2_pm_pkg::cnt_t FWAIT = 16'(`PM_FREQ_WAIT_CK);
  localparam logic [3:0]        CMD_NOP = `PM_PIN_NOP;
  localparam logic [3:0]        CMD_REF = `PM_PIN_REF;
  localparam int                RFC_I   = `PM_T_RFC_CK;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
    is_reg = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [9:0] ctrl;
  logic [7:0] half;
  logic       dll_rst;
  logic       reinit;
  logic       rst_pend;
  logic       need_ref;
  logic       pd_pre;

  wire wr_ctrl  = ce_i && reg_wr_i && is_reg(reg_addr_i, `PM_REG_CTRL);
  wire wr_cmd   = ce_i && reg_wr_i && is_reg(reg_addr_i, `PM_REG_CMD);
  wire wr_stat  = ce_i && reg_wr_i && is_reg(reg_addr_i, `PM_REG_STAT);
  wire wr_div   = ce_i && reg_wr_i && is_reg(reg_addr_i, `PM_REG_DIV);
  wire drop_now = wr_cmd && reg_wdata_i[`PM_CMD_DROP];
  wire sr_req   = ctrl[`PM_CTRL_SR_REQ];
  wire pd_req   = ctrl[`PM_CTRL_PD_REQ];
  wire bank_idl = ctrl[`PM_CTRL_BANK_IDL];

  ////////////////////////////////////////////////////////////////////////
  // Link clock divider

  logic [7:0] div_cnt;
  logic       ph;
  logic       ck_run;

  wire div_hit = (div_cnt >= half - 8'h01);
  // Pins change on the falling link edge, centred for the rising one
  wire step    = ce_i && div_hit && ph;
  wire ph_nx   = ph ^ div_hit;

  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      div_cnt    <= 8'h00;
      ph         <= 1'b0;
      ddr_ck_o   <= 1'b0;
      ddr_ck_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      div_cnt    <= div_hit ? 8'h00 : div_cnt + 8'h01;
      ph         <= ph_nx;
      ddr_ck_o   <= ck_run & ph_nx;
      ddr_ck_n_o <= ~(ck_run & ph_nx);
    end

  ////////////////////////////////////////////////////////////////////////
  // Refresh scheduling and sequencer

  ddr2_sched_if sch ();

  ddr2_refresh_sched #(
    .REFI_CK  (REFI_CK),
    .MAX_POST (`PM_MAX_POST)
  ) u_sched (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .sch       (sch.sched)
  );

  ddr2_pm_pkg::state_e state;
  ddr2_pm_pkg::state_e next_state;
  ddr2_pm_pkg::cnt_t   cnt;
  ddr2_pm_pkg::cnt_t   next_cnt;
  ddr2_pm_pkg::cnt_t   xsrd_cnt;
  ddr2_pm_pkg::cnt_t   rp_cnt;
  logic [3:0]          next_cmd;
  logic                next_cke;
  logic                next_run;
  logic                ref_issue;

  wire in_idle  = (state == ddr2_pm_pkg::ST_IDLE);
  wire in_pd    = (state == ddr2_pm_pkg::ST_PD);
  wire in_sr    = (state == ddr2_pm_pkg::ST_SR);
  wire rp_ok    = bank_idl && (rp_cnt >= RP);
  wire ref_ok   = ctrl[`PM_CTRL_REF_EN] && rp_ok;
  wire do_ref   = ref_ok && (sch.urgent ||
                  (sch.owed != 4'h0 && !sr_req && !pd_req) ||
                  (sr_req && need_ref));
  wire sr_go    = sr_req && !need_ref && rp_ok && !ddr_odt_o &&
                  !sch.urgent;
  wire pd_go    = pd_req && !ctrl[`PM_CTRL_BURST] && !sch.urgent &&
                  (xsrd_cnt == '0);
  wire pd_leave = !pd_req || sch.urgent;
  // Active exit speed follows the mode register A12 copy
  wire [15:0] exit_lat = pd_pre ? XP :
                         ctrl[`PM_CTRL_LP_EXIT] ? XARDS : XARD;
  wire freq_ok  = in_pd && pd_pre && (cnt == '0) && !ddr_odt_o;
  // A divider write in a step cycle skips that step; pins stay put
  wire div_ok   = wr_div && freq_ok && (reg_wdata_i[7:0] != 8'h00);
  wire adv      = (step || drop_now) && !div_ok;
  wire sr_exit  = in_sr && (next_state == ddr2_pm_pkg::ST_SRX);
  wire pd_entry = in_idle && (next_state == ddr2_pm_pkg::ST_PD);
  wire next_odt = ctrl[`PM_CTRL_ODT_EN] && !sr_req && !pd_req &&
                  (next_state == ddr2_pm_pkg::ST_IDLE) &&
                  (xsrd_cnt == '0);

  assign sch.tick       = step;
  assign sch.ref_issued = adv && ref_issue;
  // The device refreshes itself while in self refresh
  assign sch.clear      = in_sr;

  always_comb
  begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - 16'h0001 : cnt;
    next_cmd   = CMD_NOP;
    next_cke   = ddr_cke_o;
    next_run   = ck_run;
    ref_issue  = 1'b0;
    case (state)
      ddr2_pm_pkg::ST_IDLE:
        if (cnt == '0)
        begin
          if (do_ref)
          begin
            next_cmd   = CMD_REF;
            next_state = ddr2_pm_pkg::ST_REF;
            next_cnt   = RFC;
            ref_issue  = 1'b1;
          end
          else if (sr_go)
          begin
            next_cmd   = CMD_REF;
            next_cke   = 1'b0;
            next_state = ddr2_pm_pkg::ST_SR;
            next_cnt   = CKEM;
          end
          else if (pd_go)
          begin
            next_cke   = 1'b0;
            next_state = ddr2_pm_pkg::ST_PD;
            next_cnt   = FWAIT;
          end
        end
      ddr2_pm_pkg::ST_REF:
        if (cnt == '0)
          next_state = ddr2_pm_pkg::ST_IDLE;
      ddr2_pm_pkg::ST_PD:
        if (cnt == '0 && pd_leave)
        begin
          next_cke   = 1'b1;
          next_state = ddr2_pm_pkg::ST_PDX;
          next_cnt   = exit_lat;
        end
      ddr2_pm_pkg::ST_SR:
        if (cnt == '0)
        begin
          if (sr_req && ctrl[`PM_CTRL_CLK_STOP])
            next_run = 1'b0;
          else if (!sr_req && !ck_run)
          begin
            next_run = 1'b1;
            next_cnt = STAB;
          end
          else if (!sr_req)
          begin
            next_cke   = 1'b1;
            next_state = ddr2_pm_pkg::ST_SRX;
            next_cnt   = XSNR;
          end
        end
      ddr2_pm_pkg::ST_SRX, ddr2_pm_pkg::ST_PDX:
        if (cnt == '0)
          next_state = ddr2_pm_pkg::ST_IDLE;
      ddr2_pm_pkg::ST_FAIL:
        if (cnt == '0)
        begin
          if (rst_pend && !ck_run)
          begin
            next_run = 1'b1;
            next_cnt = STAB;
          end
          else if (rst_pend)
          begin
            next_cke   = 1'b1;
            next_state = ddr2_pm_pkg::ST_IDLE;
          end
          else
            next_run = 1'b0;
        end
      default:
        next_state = ddr2_pm_pkg::ST_IDLE;
    endcase
    if (drop_now)
    begin
      next_state = ddr2_pm_pkg::ST_FAIL;
      next_cke   = 1'b0;
      next_cnt   = DLY;
      next_cmd   = CMD_NOP;
      next_run   = ck_run;
      ref_issue  = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      state     <= ddr2_pm_pkg::ST_IDLE;
      cnt       <= '0;
      ddr_cke_o <= 1'b1;
      ddr_odt_o <= 1'b0;
      ck_run    <= 1'b1;
      {ddr_cs_n_o, ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} <= CMD_NOP;
    end
    else if (div_ok)
      cnt <= STAB;
    else if (adv)
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      ddr_cke_o <= next_cke;
      ddr_odt_o <= next_odt;
      ck_run    <= next_run;
      {ddr_cs_n_o, ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} <= next_cmd;
    end

  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      xsrd_cnt <= '0;
      rp_cnt   <= '0;
    end
    else if (ce_i)
    begin
      if (adv && sr_exit)
        xsrd_cnt <= XSRD;
      else if (step && xsrd_cnt != '0)
        xsrd_cnt <= xsrd_cnt - 16'h0001;
      if (!bank_idl)
        rp_cnt <= '0;
      else if (step && rp_cnt < RP)
        rp_cnt <= rp_cnt + 16'h0001;
    end

  ////////////////////////////////////////////////////////////////////////
  // Register storage and sticky flags

  wire clr_dll = wr_stat && reg_wdata_i[`PM_STAT_DLL_RST];
  wire clr_ini = wr_stat && reg_wdata_i[`PM_STAT_REINIT];
  wire set_dll = div_ok || (adv && pd_entry && !ctrl[`PM_CTRL_DLL_LOCK]);
  wire rst_set = wr_cmd && reg_wdata_i[`PM_CMD_RESTART];
  wire rst_clr = adv && (state == ddr2_pm_pkg::ST_FAIL) &&
                 (next_state == ddr2_pm_pkg::ST_IDLE);

  wire [31:0] stat_word = {19'h0_0000, ddr_odt_o, ddr_cke_o, reinit,
                           dll_rst, freq_ok, need_ref, sch.owed, state};
  // Command register reads as zero, like any unmapped offset
  wire [31:0] rd_mux =
    is_reg(reg_addr_i, `PM_REG_CTRL) ? {22'h00_0000, ctrl} :
    is_reg(reg_addr_i, `PM_REG_STAT) ? stat_word :
    is_reg(reg_addr_i, `PM_REG_DIV)  ? {24'h00_0000, half} : 32'h0000_0000;

  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      ctrl     <= `PM_CTRL_RST;
      half     <= 8'(`PM_CK_HALF);
      dll_rst  <= 1'b0;
      reinit   <= 1'b0;
      rst_pend <= 1'b0;
      need_ref <= 1'b0;
      pd_pre   <= 1'b1;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata_i[9:0];
      if (div_ok)
        half <= reg_wdata_i[7:0];
      dll_rst  <= set_dll | (dll_rst & ~clr_dll);
      reinit   <= drop_now | (reinit & ~clr_ini);
      rst_pend <= rst_set | (rst_pend & ~rst_clr);
      if (adv && sr_exit)
        need_ref <= 1'b1;
      else if (adv && ref_issue)
        need_ref <= 1'b0;
      if (adv && pd_entry)
        pd_pre <= !ctrl[`PM_CTRL_ROW_OPEN];
    end

  always_ff @(posedge clock_i)
    if (sys_rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (ce_i)
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  ddr2_pm_pkg::cnt_t since_ref;
  wire ref_allowed = bank_idl && rp_ok;
  wire [3:0] pins  = {ddr_cs_n_o, ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o};

  always_ff @(posedge clock_i)
    if (sys_rst_i)
      since_ref <= '0;
    else if (adv && ref_issue)
      since_ref <= 16'h0001;
    else if (step && since_ref != '0 && since_ref != 16'hFFFF)
      since_ref <= since_ref + 16'h0001;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sr_enter;
    $rose(in_sr);
  endsequence

  a_ref_bank_idle: assert property ($rose(state == ddr2_pm_pkg::ST_REF)
    |-> $past(ref_allowed))
    else $error("refresh issued without idle banks");
  a_ref_gap: assert property ((adv && ref_issue)
    |-> (since_ref == '0 || since_ref > RFC_I))
    else $error("refresh spacing below tRFC");
  a_sr_odt_off: assert property (s_sr_enter
    |-> !$past(ddr_odt_o) && !ddr_cke_o)
    else $error("self refresh entered with ODT on");
  a_sr_cke_low: assert property (in_sr |-> !ddr_cke_o)
    else $error("CKE high inside self refresh");
  a_clk_before_exit: assert property ($rose(ddr_cke_o) |-> ck_run)
    else $error("CKE raised with clock stopped");
  a_xsnr_nop: assert property ((state == ddr2_pm_pkg::ST_SRX)
    |-> pins == CMD_NOP && ddr_cke_o)
    else $error("command during self refresh exit");
  a_xsrd_cke: assert property ((xsrd_cnt != '0 && !in_sr &&
    state != ddr2_pm_pkg::ST_FAIL) |-> ddr_cke_o && !ddr_odt_o)
    else $error("CKE or ODT wrong during tXSRD");
  a_sr_after_ref: assert property (s_sr_enter |-> !$past(need_ref))
    else $error("self refresh re-entry without refresh");
  a_pd_no_burst: assert property ($rose(in_pd)
    |-> !$past(ctrl[`PM_CTRL_BURST]) && !ddr_cke_o)
    else $error("power-down entered during burst");
  a_pd_limit: assert property ((in_pd && sch.urgent && step &&
    cnt == '0 && !div_ok) |=> !in_pd && ddr_cke_o)
    else $error("power-down held past refresh limit");
  a_freq_wait: assert property ($changed(half)
    |-> $past(freq_ok) && !ddr_cke_o && !ddr_odt_o)
    else $error("clock changed outside precharge power-down");

endmodule

// File: common/ddr2_pm_defs.svh
`ifndef DDR2_PM_DEFS_SVH
`define DDR2_PM_DEFS_SVH

// System clock and default link clock half period in system clocks
`define PM_CLK_NS        20
`define PM_CK_HALF       4
`define PM_TCK_NS        (2 * `PM_CK_HALF * `PM_CLK_NS)

// Times in ns, converted to link clock cycles
`define PM_T_RP_NS       15
`define PM_T_RFC_NS      75
`define PM_T_XSNR_NS     85
`define PM_T_REFI_NS     7800
`define PM_T_RP_CK       ((`PM_T_RP_NS + `PM_TCK_NS - 1) / `PM_TCK_NS)
`define PM_T_RFC_CK      ((`PM_T_RFC_NS + `PM_TCK_NS - 1) / `PM_TCK_NS)
`define PM_T_XSNR_CK     ((`PM_T_XSNR_NS + `PM_TCK_NS - 1) / `PM_TCK_NS)
`define PM_T_REFI_CK     (`PM_T_REFI_NS / `PM_TCK_NS)

// Times given in link clock cycles, and the refresh posting limit
`define PM_T_XSRD_CK     200
`define PM_T_XP_CK       2
`define PM_T_XARD_CK     2
`define PM_T_XARDS_CK    6
`define PM_T_CKE_CK      3
`define PM_T_DELAY_CK    2
`define PM_STABLE_CK     4
`define PM_FREQ_WAIT_CK  2
`define PM_MAX_POST      8

// Register offsets
`define PM_REG_CTRL      8'h00
`define PM_REG_CMD       8'h04
`define PM_REG_STAT      8'h08
`define PM_REG_DIV       8'h0C

// Control register fields
`define PM_CTRL_REF_EN   0
`define PM_CTRL_SR_REQ   1
`define PM_CTRL_PD_REQ   2
`define PM_CTRL_LP_EXIT  3
`define PM_CTRL_ROW_OPEN 4
`define PM_CTRL_BANK_IDL 5
`define PM_CTRL_DLL_LOCK 6
`define PM_CTRL_ODT_EN   7
`define PM_CTRL_CLK_STOP 8
`define PM_CTRL_BURST    9
`define PM_CTRL_RST      10'h000

// Command register fields
`define PM_CMD_DROP      0
`define PM_CMD_RESTART   1

// Status register sticky flags
`define PM_STAT_DLL_RST  9
`define PM_STAT_REINIT   10

// Pin commands {cs_n, ras_n, cas_n, we_n}
`define PM_PIN_NOP       4'h7
`define PM_PIN_REF       4'h1

`endif

// File: common/ddr2_pm_pkg.sv
package ddr2_pm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_REF  = 3'h1,
    ST_PD   = 3'h3,
    ST_PDX  = 3'h2,
    ST_SR   = 3'h6,
    ST_SRX  = 3'h7,
    ST_FAIL = 3'h5
  } state_e;

  typedef logic [15:0] cnt_t;

endpackage

// File: common/ddr2_sched_if.sv
`timescale 1ns/1ps
interface ddr2_sched_if;
  logic       tick;
  logic       ref_issued;
  logic       clear;
  logic [3:0] owed;
  logic       urgent;

  modport sched (
    input  tick,
    input  ref_issued,
    input  clear,
    output owed,
    output urgent
  );

  modport ctrl (
    output tick,
    output ref_issued,
    output clear,
    input  owed,
    input  urgent
  );
endinterface

// File: logic/ddr2_refresh_sched.sv
`timescale 1ns/1ps
`include "ddr2_pm_defs.svh"

module ddr2_refresh_sched #(
  parameter int unsigned REFI_CK  = `PM_T_REFI_CK,
  parameter int unsigned MAX_POST = `PM_MAX_POST
) (
  // Clock, reset, enable
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  // Controller side
  ddr2_sched_if.sched       sch
);

  localparam ddr2_pm_pkg::cnt_t LAST = ddr2_pm_pkg::cnt_t'(REFI_CK - 1);
  localparam logic [3:0]        MAXP = 4'(MAX_POST);

  ddr2_pm_pkg::cnt_t ival;
  logic [3:0]        next_owed;

  wire ival_end = sch.tick && (ival == LAST);
  wire owe_more = ival_end && !sch.ref_issued && (sch.owed != MAXP);
  wire owe_less = sch.ref_issued && !ival_end && (sch.owed != 4'h0);

  // Count of intervals whose refresh is still owed
  assign next_owed = sch.clear ? 4'h0 :
                     owe_more  ? sch.owed + 4'h1 :
                     owe_less  ? sch.owed - 4'h1 : sch.owed;

  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      ival       <= '0;
      sch.owed   <= 4'h0;
      sch.urgent <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sch.clear || ival_end)
        ival <= '0;
      else if (sch.tick)
        ival <= ival + 16'h0001;
      sch.owed   <= next_owed;
      sch.urgent <= (next_owed >= MAXP);
    end

  // Saturation at the posting limit forces the refresh before a ninth
  a_owed_limit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    sch.owed <= MAXP)
    else $error("refresh posting limit exceeded");

endmodule

// File: bench/ddr2_dev_model.sv
`timescale 1ns/1ps
module ddr2_dev_model #(
  parameter int RFC_CK = 1,
  parameter int CKE_CK = 3
) (
  // Pins from the controller
  input  wire logic ck_i,
  input  wire logic cke_i,
  input  wire logic cs_n_i,
  input  wire logic ras_n_i,
  input  wire logic cas_n_i,
  input  wire logic we_n_i,
  // Observed device state
  output int        refs_o,
  output int        srs_o,
  output int        pds_o,
  output int        errs_o,
  output logic      in_sr_o,
  output logic      in_pd_o
);
  logic [3:0] cmd;
  logic       cke_q;
  int         since_ref;
  int         sr_len;

  // Deselect acts as NOP, other strobes ignored
  assign cmd = cs_n_i ? 4'h7 : {1'b0, ras_n_i, cas_n_i, we_n_i};

  initial
  begin
    refs_o = 0;
    srs_o = 0;
    pds_o = 0;
    errs_o = 0;
    in_sr_o = 1'b0;
    in_pd_o = 1'b0;
    cke_q = 1'b1;
    since_ref = 100;
    sr_len = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ck_i)
  begin
    cke_q <= cke_i;
    since_ref <= since_ref + 1;
    if (in_sr_o)
    begin
      // Only CKE is looked at here; internal timer keeps data
      sr_len <= sr_len + 1;
      if (cke_i)
      begin
        in_sr_o <= 1'b0;
        since_ref <= 0;
        if (sr_len < CKE_CK - 1)
          errs_o <= errs_o + 1;
      end
    end
    else if (in_pd_o)
    begin
      // Buffers off except CKE; exit only with NOP
      if (cke_i)
      begin
        in_pd_o <= 1'b0;
        if (cmd !== 4'h7)
          errs_o <= errs_o + 1;
      end
    end
    else if (!cke_i && cke_q)
    begin
      if (cmd === 4'h1)
      begin
        in_sr_o <= 1'b1;
        srs_o <= srs_o + 1;
        sr_len <= 0;
      end
      else if (cmd === 4'h7)
      begin
        in_pd_o <= 1'b1;
        pds_o <= pds_o + 1;
      end
      else
        errs_o <= errs_o + 1;
    end
    else if (cmd === 4'h1)
    begin
      // Address from internal counter; banks idle afterwards
      refs_o <= refs_o + 1;
      since_ref <= 0;
      if (since_ref < RFC_CK)
        errs_o <= errs_o + 1;
    end
    else if (cmd !== 4'h7)
      errs_o <= errs_o + 1;
  end
endmodule

// File: bench/ddr2_pm_ctrl_tb.sv
`timescale 1ns/1ps
`include "ddr2_pm_defs.svh"
module ddr2_pm_ctrl_tb;
  localparam logic [31:0] BASE = 32'h0000_0061; // ref_en, idle, dll
  localparam logic [31:0] PD   = 32'h0000_0004;
  logic        clock_i, sys_rst_i, ce_i, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, in_sr, in_pd;
  int          refs, srs, pds, errs, n, div, k;
  int          num_errors, total_checks, cycles;

  ddr2_pm_ctrl #(.REFI_CK(8), .XSRD_CK(10)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .ddr_ck_o(ck),
    .ddr_ck_n_o(ck_n), .ddr_cke_o(cke), .ddr_cs_n_o(cs_n),
    .ddr_ras_n_o(ras_n), .ddr_cas_n_o(cas_n), .ddr_we_n_o(we_n),
    .ddr_odt_o(odt));
  ddr2_dev_model mem (
    .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .refs_o(refs), .srs_o(srs),
    .pds_o(pds), .errs_o(errs), .in_sr_o(in_sr), .in_pd_o(in_pd));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ck_cycles(input int half);
    return 32'(2 * half);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_state(input logic [2:0] s);
    logic [31:0] r;
    r = {29'h0, ~s};
    for (int i = 0; i < 400 && r[2:0] !== s; i++)
      rd(`PM_REG_STAT, r);
    // Device registers the new pin state only at the next CK rise
    @(posedge ck);
    #1 check({29'h0, r[2:0]}, {29'h0, s});
  endtask

  // Counts CK high samples; a stopped CK is held low
  task automatic ck_high(output int cnt);
    cnt = 0;
    repeat (100) @(posedge clock_i) cnt += int'(ck);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    {sys_rst_i, ce_i, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 42'h0};
    void'($urandom(32'hc005));
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1 check({cke, cs_n, ras_n, cas_n, we_n, odt}, 32'h0000_002E);
    rd(`PM_REG_STAT, v);
    check({v[12:11], v[2:0]}, 32'h0000_0008);
    rd(`PM_REG_DIV, v);
    check(v, 32'h0000_0004);
    for (k = 0; k < 3; k++)
    begin
      div = 16 + $urandom_range(0, 239);
      wr(8'(div), $urandom);
      rd(8'(div), v);
      check(v, 32'h0);
    end
    @(posedge ck);
    n = int'($time);
    @(posedge ck);
    check(32'((int'($time) - n) / 20), ck_cycles(4));
    #1 check(32'(ck_n), 32'(!ck));
    // Banks busy and refresh off: owed saturates, nothing issued
    wr(`PM_REG_CTRL, 32'h0000_0040);
    repeat (800) @(posedge clock_i);
    rd(`PM_REG_STAT, v);
    check({28'h0, v[6:3]}, 32'h0000_0008);
    check(32'(refs), 32'h0);
    wr(`PM_REG_CTRL, BASE);
    for (k = 0; k < 3000 && refs < 8; k++) @(posedge clock_i);
    check(32'(refs >= 8), 32'h1);
    wr(`PM_REG_CTRL, BASE | PD | 32'h0000_0200);
    n = pds;
    repeat (300) @(posedge clock_i);
    check(32'(pds), 32'(n));
    // Let owed refreshes drain so the limit does not cut power-down
    wr(`PM_REG_CTRL, BASE);
    repeat (400) @(posedge clock_i);
    // Precharge power-down, then a random frequency change
    wr(`PM_REG_CTRL, BASE | PD);
    wait_state(3'h3);
    check({cke, in_pd}, 32'h1);
    // Two link clocks after CKE falls before the divider may change
    repeat (40) @(posedge clock_i);
    div = $urandom_range(2, 7);
    wr(`PM_REG_DIV, 32'(div));
    rd(`PM_REG_DIV, v);
    check(v, 32'(div));
    rd(`PM_REG_STAT, v);
    check(32'(v[9]), 32'h1);
    @(posedge ck);
    n = int'($time);
    @(posedge ck);
    check(32'((int'($time) - n) / 20), ck_cycles(div));
    wr(`PM_REG_CTRL, BASE);
    wait_state(3'h0);
    check({cke, in_pd}, 32'h2);
    wr(`PM_REG_DIV, 32'h0000_0009);
    rd(`PM_REG_DIV, v);
    check(v, 32'(div));
    wr(`PM_REG_STAT, 32'h0000_0200);
    rd(`PM_REG_STAT, v);
    check(32'(v[9]), 32'h0);
    // Active power-down with slow exit
    wr(`PM_REG_CTRL, 32'h0000_005D);
    wait_state(3'h3);
    wr(`PM_REG_CTRL, 32'h0000_0059);
    wait_state(3'h0);
    // Termination follows its enable while idle, refresh off
    wr(`PM_REG_CTRL, 32'h0000_00E0);
    repeat (300) @(posedge clock_i);
    check(32'(odt), 32'h1);
    check(32'(srs), 32'h0);
    for (k = 0; k < 2; k++)
    begin
      n = refs;
      wr(`PM_REG_CTRL, BASE | 32'h0000_0182);
      wait_state(3'h6);
      check({cke, odt, in_sr}, 32'h1);
      if (k == 1)
        check(32'(refs > n), 32'h1);
      // CK stops only after the minimum self refresh time
      repeat (80) @(posedge clock_i);
      ck_high(n);
      check(32'(n), 32'h0);
      wr(`PM_REG_CTRL, BASE);
      wait_state(3'h0);
      check({cke, in_sr}, 32'h2);
    end
    // Clock enable low freezes the link clock
    ce_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    n = int'(ck);
    ck_high(k);
    check(32'(k), 32'(100 * n));
    ce_i <= 1'b1;
    // Sudden CKE drop, then restart
    wr(`PM_REG_CMD, 32'h0000_0001);
    @(posedge clock_i);
    #1 check(32'(cke), 32'h0);
    rd(`PM_REG_STAT, v);
    check({29'h0, v[10], v[2:0] === 3'h5, 1'b0}, 32'h6);
    repeat (100) @(posedge clock_i);
    ck_high(n);
    check(32'(n), 32'h0);
    wr(`PM_REG_CMD, 32'h0000_0002);
    wait_state(3'h0);
    check(32'(cke), 32'h1);
    wr(`PM_REG_STAT, 32'h0000_0400);
    rd(`PM_REG_STAT, v);
    check(32'(v[10]), 32'h0);
    check(32'(errs), 32'h0);
    tally_and_finish();
  end
endmodule
